//--- tdcr_pkg.sv
package tdcr_pkg;
	localparam int unsigned CHANNELS = 256;
	localparam int unsigned DWORDS_PER_CH = 6;
	localparam int unsigned WORDS_PER_CH = 12;
	localparam int unsigned ADDR_W = 12;
	localparam logic [11:0] OFF_INDIRECT_SELECT = 12'h870;
	localparam logic [11:0] OFF_CFG_DATA = 12'h874;
	localparam logic [15:0] RESET_INDIRECT_SELECT = 16'h0000;
	localparam logic [15:0] RESET_CFG_DATA = 16'h0000;
	localparam int unsigned SEL_CH_LSB = 0;
	localparam int unsigned SEL_WORD_LSB = 8;
	localparam int unsigned SEL_RW_BIT = 14;
	localparam int unsigned SEL_BUSY_BIT = 15;
	localparam logic [3:0] WORD_HOST_WRITABLE = 4'h2;
	localparam logic [3:0] WORD_LAST = 4'hb;
	localparam logic [3:0] WORD_D1_HI = 4'h3;
	localparam logic [3:0] WORD_D4_HI = 4'h9;
	// field positions within the upper word of dword 1
	localparam int unsigned D1H_CHAIN_VALID = 0;
	localparam int unsigned D1H_EOF = 1;
	localparam int unsigned D1H_STD_STATE_LSB = 2;
	localparam int unsigned D1H_PRI_STATE_LSB = 4;
	localparam int unsigned D1H_PRI_IN_PROGRESS = 6;
	localparam logic [15:0] D1H_USED_MASK = 16'h007f;
	// bit 1 of the lower word of dword 1 is done-queue select
	localparam int unsigned D1L_DONE_SEL = 1;
	localparam logic [1:0] QSTATE_NONE = 2'h0;
	localparam logic [1:0] QSTATE_NEXT = 2'h1;
	localparam logic [1:0] QSTATE_PEND = 2'h2;
	localparam logic [1:0] QSTATE_BOTH = 2'h3;
	// ram access latency in cycles (one registered read stage)
	localparam int unsigned RAM_LATENCY = 1;
endpackage

//--- tdcr_word_ram.sv
`timescale 1ns/1ps
module tdcr_word_ram #(
	parameter int unsigned DEPTH = 3072,
	parameter int unsigned AW = 12
)(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic a_we,
	input wire logic [AW-1:0] a_addr,
	input wire logic [15:0] a_wdata,
	output logic [15:0] a_rdata,
	input wire logic b_we,
	input wire logic [AW-1:0] b_addr,
	input wire logic [15:0] b_wdata,
	output logic [15:0] b_rdata
);
	logic [15:0] mem_reg [DEPTH];
	genvar gi;
	// flip-flop storage, reset so that reads are never unknown
	generate
		for (gi = 0; gi < DEPTH; gi++)
		begin : g_word
			always_ff @(posedge core_clk or negedge rstn)
			begin
				if (!rstn)
					mem_reg[gi] <= 16'h0000;
				else if (a_we && a_addr == AW'(gi))
					mem_reg[gi] <= a_wdata;
				else if (b_we && b_addr == AW'(gi))
					mem_reg[gi] <= b_wdata;
			end
		end
	endgenerate
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			a_rdata <= 16'h0000;
			b_rdata <= 16'h0000;
		end
		else
		begin
			a_rdata <= mem_reg[a_addr];
			b_rdata <= mem_reg[b_addr];
		end
	end
endmodule

//--- tdcr_top.sv
`timescale 1ns/1ps
module tdcr_top #(
	parameter int unsigned CHANNELS = tdcr_pkg::CHANNELS
)(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [11:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	input wire logic dma_we,
	input wire logic [7:0] dma_channel,
	input wire logic [3:0] dma_word,
	input wire logic [15:0] dma_wdata,
	output logic [15:0] dma_rdata,
	output logic done_sel_packet
);
	localparam int unsigned DEPTH = CHANNELS * tdcr_pkg::WORDS_PER_CH;
	typedef enum logic [1:0] {TDCR_IDLE, TDCR_RD_WAIT, TDCR_RD_DONE} tdcr_st_e;
	tdcr_st_e state_reg;
	logic [7:0] channel_select_reg;
	logic [3:0] ram_word_select_reg;
	logic indirect_read_write_reg;
	logic indirect_busy_reg;
	logic [15:0] tx_dma_cfg_data_reg;
	logic sel_wr;
	logic data_wr;
	logic word_ok;
	logic host_we;
	logic [11:0] host_addr;
	logic [11:0] dma_addr;
	logic [15:0] host_rdata;
	logic [15:0] ram_dma_rdata;
	logic [15:0] dma_wdata_masked;
	logic [15:0] sel_view;
	logic chain_valid_flag;
	logic frame_end_flag;
	logic [1:0] standard_queue_state;
	logic [1:0] priority_queue_state;
	logic priority_in_progress;
	logic [15:0] d1h;
	logic dma_word_ok;
	logic dma_store;

	assign sel_wr = reg_wr && reg_addr == tdcr_pkg::OFF_INDIRECT_SELECT;
	assign data_wr = reg_wr && reg_addr == tdcr_pkg::OFF_CFG_DATA;
	assign word_ok = ram_word_select_reg <= tdcr_pkg::WORD_LAST;
	// channel times twelve plus word; dwords are word pairs
	assign host_addr = 12'({channel_select_reg, 4'h0})
		- 12'({channel_select_reg, 2'h0}) + 12'(ram_word_select_reg);
	assign dma_addr = 12'({dma_channel, 4'h0})
		- 12'({dma_channel, 2'h0}) + 12'(dma_word);
	// host writes land only on the lower word of dword 1
	assign host_we = state_reg == TDCR_IDLE && indirect_busy_reg
		&& !indirect_read_write_reg
		&& ram_word_select_reg == tdcr_pkg::WORD_HOST_WRITABLE;

	// dword 1 upper word: only the dma's own state fields are kept
	assign chain_valid_flag = dma_wdata[tdcr_pkg::D1H_CHAIN_VALID];
	assign frame_end_flag = dma_wdata[tdcr_pkg::D1H_EOF];
	assign standard_queue_state =
		dma_wdata[tdcr_pkg::D1H_STD_STATE_LSB +: 2];
	assign priority_queue_state =
		dma_wdata[tdcr_pkg::D1H_PRI_STATE_LSB +: 2];
	assign priority_in_progress =
		dma_wdata[tdcr_pkg::D1H_PRI_IN_PROGRESS];
	always_comb
	begin
		d1h = 16'h0000;
		d1h[tdcr_pkg::D1H_CHAIN_VALID] = chain_valid_flag;
		d1h[tdcr_pkg::D1H_EOF] = frame_end_flag;
		d1h[tdcr_pkg::D1H_STD_STATE_LSB +: 2] = standard_queue_state;
		d1h[tdcr_pkg::D1H_PRI_STATE_LSB +: 2] = priority_queue_state;
		d1h[tdcr_pkg::D1H_PRI_IN_PROGRESS] = priority_in_progress;
	end
	// unused dword 1 and dword 4 upper bits are stored as zero
	always_comb
	begin
		dma_wdata_masked = dma_wdata;
		if (dma_word == tdcr_pkg::WORD_D1_HI)
			dma_wdata_masked = d1h;
		else if (dma_word == tdcr_pkg::WORD_D4_HI)
			dma_wdata_masked = 16'h0000;
	end

	// words above 1011 would alias into the next channel's dwords
	assign dma_word_ok = dma_word <= tdcr_pkg::WORD_LAST;
	// host port wins a clash; pointer words pass through unchanged
	assign dma_store = dma_we && dma_word_ok
		&& !(host_we && host_addr == dma_addr);

	tdcr_word_ram #(
		.DEPTH(DEPTH),
		.AW(tdcr_pkg::ADDR_W)
	) u_ram (
		.core_clk(core_clk),
		.rstn(rstn),
		.a_we(host_we),
		.a_addr(host_addr),
		.a_wdata(tx_dma_cfg_data_reg),
		.a_rdata(host_rdata),
		.b_we(dma_store),
		.b_addr(dma_addr),
		.b_wdata(dma_wdata_masked),
		.b_rdata(ram_dma_rdata)
	);
	assign dma_rdata = ram_dma_rdata;

	// select is frozen while busy so a running access keeps its target

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			channel_select_reg <= tdcr_pkg::RESET_INDIRECT_SELECT[7:0];
			ram_word_select_reg <= tdcr_pkg::RESET_INDIRECT_SELECT[11:8];
			indirect_read_write_reg <= tdcr_pkg::RESET_INDIRECT_SELECT[14];
		end
		else if (sel_wr && !indirect_busy_reg)
		begin
			channel_select_reg <= reg_wdata[7:0];
			ram_word_select_reg <= reg_wdata[11:8];
			indirect_read_write_reg <= reg_wdata[tdcr_pkg::SEL_RW_BIT];
		end
	end

	// indirect access sequencer; writes take one cycle, reads three
	// a read with a word above 1011 drops busy with no fetch
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg <= TDCR_IDLE;
			indirect_busy_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
			TDCR_IDLE:
				if (indirect_busy_reg)
				begin
					if (indirect_read_write_reg && word_ok)
						state_reg <= TDCR_RD_WAIT;
					else
						indirect_busy_reg <= 1'b0;
				end
				else if (sel_wr)
					indirect_busy_reg <= 1'b1;
			TDCR_RD_WAIT:
				state_reg <= TDCR_RD_DONE;
			TDCR_RD_DONE:
			begin
				state_reg <= TDCR_IDLE;
				indirect_busy_reg <= 1'b0;
			end
			default:
				state_reg <= TDCR_IDLE;
			endcase
		end
	end

	// a fetch overrides a host write in the same cycle
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			tx_dma_cfg_data_reg <= tdcr_pkg::RESET_CFG_DATA;
		else if (state_reg == TDCR_RD_DONE)
			tx_dma_cfg_data_reg <= host_rdata;
		else if (data_wr && !indirect_busy_reg)
			tx_dma_cfg_data_reg <= reg_wdata;
	end

	always_comb
	begin
		sel_view = 16'h0000;
		sel_view[7:0] = channel_select_reg;
		sel_view[11:8] = ram_word_select_reg;
		sel_view[tdcr_pkg::SEL_RW_BIT] = indirect_read_write_reg;
		sel_view[tdcr_pkg::SEL_BUSY_BIT] = indirect_busy_reg;
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			reg_rdata <= 16'h0000;
		else if (reg_rd && reg_addr == tdcr_pkg::OFF_INDIRECT_SELECT)
			reg_rdata <= sel_view;
		else if (reg_rd && reg_addr == tdcr_pkg::OFF_CFG_DATA)
			reg_rdata <= tx_dma_cfg_data_reg;
		else
			reg_rdata <= 16'h0000;
	end

	// exported so the dma engine knows when to post to the done queue
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			done_sel_packet <= 1'b1;
		else if (host_we)
			done_sel_packet <= !tx_dma_cfg_data_reg[tdcr_pkg::D1L_DONE_SEL];
	end
endmodule

//--- tdcr_props.sv
`timescale 1ns/1ps
module tdcr_props (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [11:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic dma_we,
	input wire logic [7:0] dma_channel,
	input wire logic [3:0] dma_word,
	input wire logic [15:0] dma_wdata,
	input wire logic [15:0] dma_rdata,
	input wire logic done_sel_packet
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	logic [15:0] dma_keep;
	// bits that the ram keeps for the word being written
	always_comb
	begin
		dma_keep = 16'hffff;
		if (dma_word == tdcr_pkg::WORD_D1_HI)
			dma_keep = tdcr_pkg::D1H_USED_MASK;
		else if (dma_word == tdcr_pkg::WORD_D4_HI)
			dma_keep = 16'h0000;
	end
	sequence s_sel(rw);
		reg_wr && reg_addr == 12'h870 && reg_wdata[14] == rw;
	endsequence
	sequence s_poll;
		reg_rd && reg_addr == 12'h870;
	endsequence
	property p_idle; !reg_rd |=> reg_rdata == 16'h0; endproperty
	a_idle: assert property (p_idle) else $error("rdata idle");
	property p_unmap; reg_rd && reg_addr[3:0] == 4'h8 |=> reg_rdata == 16'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped");
	property p_busy; s_sel(1'b0) ##1 s_poll |=> reg_rdata[15]; endproperty
	a_busy: assert property (p_busy) else $error("busy low");
	property p_wdone; s_sel(1'b0) ##3 s_poll |=> !reg_rdata[15]; endproperty
	a_wdone: assert property (p_wdone) else $error("write busy");
	property p_rdone; s_sel(1'b1) ##5 s_poll |=> !reg_rdata[15]; endproperty
	a_rdone: assert property (p_rdone) else $error("read busy");
	property p_selb;
		s_sel(1'b1) ##1 s_poll |=> reg_rdata[11:0] == $past(reg_wdata[11:0], 2);
	endproperty
	a_selb: assert property (p_selb) else $error("select");
	property p_dsel;
		$changed(done_sel_packet) |-> $past(reg_wr) || $past(reg_wr, 2);
	endproperty
	a_dsel: assert property (p_dsel) else $error("done sel");
	// address held two cycles so either read latency has settled
	property p_dma;
		dma_we ##1 (!dma_we && $stable({dma_channel, dma_word}))[*2]
			|=> dma_rdata
			== ($past(dma_wdata, 3) & $past(dma_keep, 3));
	endproperty
	a_dma: assert property (p_dma) else $error("dma word");
endmodule
bind tdcr_top tdcr_props tdcr_props_inst (.*);

//--- tdcr_dma_model.sv
`timescale 1ns/1ps
module tdcr_dma_model (
	input wire logic core_clk,
	output logic dma_we = 1'b0,
	output logic [7:0] dma_channel = 8'h00,
	output logic [3:0] dma_word = 4'h0,
	output logic [15:0] dma_wdata = 16'h0
);
	// word layout is by address only: state, pointers, flag all one path
	task automatic put(input logic [7:0] c, input logic [3:0] w,
		input logic [15:0] d);
		@(posedge core_clk);
		dma_we <= 1'b1;
		dma_channel <= c;
		dma_word <= w;
		dma_wdata <= d;
		@(posedge core_clk);
		dma_we <= 1'b0;
		dma_wdata <= ~d;
		repeat (3) @(posedge core_clk);
	endtask
endmodule

//--- testbench.sv
`timescale 1ns/1ps
`define CK(a, e) checks++; \
	if ((a) !== (e)) \
	begin \
		err_total++; \
		$display("FAIL t=%0t got %h exp %h", $time, a, e); \
	end
module testbench;
	logic core_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [11:0] reg_addr = 12'h0;
	logic [15:0] reg_wdata = 16'h0, reg_rdata, dma_rdata, v, d;
	logic dma_we, done_sel_packet;
	logic [7:0] dma_channel;
	logic [3:0] dma_word;
	logic [15:0] dma_wdata;
	int err_total = 0, checks = 0;
	initial
	begin
		forever #4 core_clk = ~core_clk;
	end
	tdcr_top tdcr_top_inst (.*);
	tdcr_dma_model tdcr_dma_model_inst (.*);
	task automatic end_of_test;
		$display("errors %0d checks %0d", err_total, checks);
		if (err_total == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// a write stays up until the next read lowers it
	task automatic wr(input logic [11:0] a, input logic [15:0] x);
		@(posedge core_clk);
		reg_rd <= 1'b0;
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= x;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic ind(input logic [7:0] c, input logic [3:0] w, input logic rw);
		int n;
		n = 0;
		wr(12'h870, {1'b0, rw, 2'b00, w, c});
		do
		begin
			rd(12'h870);
			n++;
		end
		while (v[15] !== 1'b0 && n < 10);
		if (v[15] !== 1'b0)
		begin
			err_total++;
			end_of_test();
		end
	endtask
	task automatic hrd(input logic [7:0] c, input logic [3:0] w,
		input logic [15:0] e);
		ind(c, w, 1'b1);
		rd(12'h874);
		`CK(v, e)
	endtask
	task automatic hwr(input logic [7:0] c, input logic [3:0] w,
		input logic [15:0] x);
		wr(12'h874, x);
		ind(c, w, 1'b0);
	endtask
	initial
	begin
		repeat (12) @(posedge core_clk);
		rstn <= 1'b1;
		rd(12'h870);
		`CK(v, 16'h0)
		rd(12'h874);
		`CK(v, 16'h0)
		`CK(done_sel_packet, 1'b1)
		wr(12'h874, 16'h1234);
		rd(12'h874);
		`CK(v, 16'h1234)
		rd(12'h878);
		`CK(v, 16'h0)
		hwr(8'hff, 4'h2, 16'h0003);
		hrd(8'hff, 4'h2, 16'h0003);
		`CK(done_sel_packet, 1'b0)
		hwr(8'h00, 4'h3, 16'hbeef);
		hrd(8'h00, 4'h3, 16'h0);
		for (int w = 0; w < 12; w++)
		begin
			d = 16'h5a40 | 16'(w);
			tdcr_dma_model_inst.put(8'h80, w[3:0], d);
			// unused fields come back as zero by choice
			if (w == 3)
				d = d & tdcr_pkg::D1H_USED_MASK;
			if (w == 9)
				d = 16'h0;
			hrd(8'h80, w[3:0], d);
		end
		// a word above 1011 is refused: no fetch, data register kept
		hrd(8'h80, 4'hc, 16'h5a4b);
		hwr(8'hff, 4'h2, 16'h0);
		`CK(done_sel_packet, 1'b1)
		end_of_test();
	end
endmodule
